// ==== core/oac_control_bank.sv ====
// control register bank of the optical front end with its sequencing timebase
// assumes a host on the two-wire link and result words from the converter on ref_clk_in
//
// Contract
// (R1) soft reset bit resets device, self-clears
// (R2) hold-clear bit freezes timebase at zero
// (R3) readback bit selects write or readback mode
// (R4) result words readable regardless of readback bit
// (R5) control word write-only, zero after reset
// (R6) address 1: led2 sample begin, 16 bits
// (R7) address 2: led2 sample finish, 16 bits
// (R8) address 3: led1 drive begin, 16 bits
// (R9) any reset clears every register; soft reset does not clear the five phase output registers or the link slave
// (R10) phases active from begin through finish count
`timescale 1ns/10ps
`include "oac_consts.svh"

module oac_control_bank
    import oac_pkg::*;
#(
    parameter logic [15:0] TIMEBASE_LAST = 16'hFFFF
)
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [23:0] avg_led2_minus_ambient_in,
    input wire logic [23:0] avg_led1_minus_ambient_in,
    output logic [15:0] timebase_count_out,
    output logic led2_sample_phase_out,
    output logic led1_drive_begin_out,
    output logic timing_pulse_phase_out,
    output logic led3_drive_phase_out,
    output logic powerdown_window_finish_out,
    output logic [2:0] pulse_rate_divider_out,
    output logic [19:0] offset_cancel_out,
    output logic decimation_on_out,
    output logic [2:0] decimation_ratio_out
);
    // ----------------------------------------
    // link slave
    // ----------------------------------------
    logic [7:0] reg_addr;
    logic [23:0] wr_word;
    logic wr_pulse;
    logic [23:0] read_word;

    oac_link_slave u_link (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_out(sda_out),
        .sda_oe_out(sda_oe_out),
        .rd_word_in(read_word),
        .reg_addr_out(reg_addr),
        .wr_word_out(wr_word),
        .wr_pulse_out(wr_pulse)
    );

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction

    wire wr_ctrl = wr_pulse & hit(reg_addr, `OAC_ADDR_CONTROL);
    wire wr_led2_begin = wr_pulse & hit(reg_addr, `OAC_ADDR_LED2_BEGIN);
    wire wr_led2_finish = wr_pulse & hit(reg_addr, `OAC_ADDR_LED2_FINISH);
    wire wr_led1_begin = wr_pulse & hit(reg_addr, `OAC_ADDR_LED1_BEGIN);
    wire wr_pdn_finish = wr_pulse & hit(reg_addr, `OAC_ADDR_PDN_FINISH);
    wire wr_tg_begin = wr_pulse & hit(reg_addr, `OAC_ADDR_TG_BEGIN);
    wire wr_tg_finish = wr_pulse & hit(reg_addr, `OAC_ADDR_TG_FINISH);
    wire wr_led3_begin = wr_pulse & hit(reg_addr, `OAC_ADDR_LED3_BEGIN);
    wire wr_led3_finish = wr_pulse & hit(reg_addr, `OAC_ADDR_LED3_FINISH);
    wire wr_prf = wr_pulse & hit(reg_addr, `OAC_ADDR_PRF_DIV);
    wire wr_offset = wr_pulse & hit(reg_addr, `OAC_ADDR_OFFSET_DAC);
    wire wr_dec = wr_pulse & hit(reg_addr, `OAC_ADDR_DECIMATION);

    // ----------------------------------------
    // register storage
    // ----------------------------------------
    logic soft_reset;
    logic timebase_hold_clear;
    logic readback_on;
    logic [15:0] led2_sample_begin;
    logic [15:0] led2_sample_finish;
    logic [15:0] led1_drive_begin;
    logic [15:0] powerdown_window_finish;
    logic [15:0] timing_pulse_begin;
    logic [15:0] timing_pulse_finish;
    logic [15:0] led3_drive_begin;
    logic [15:0] led3_drive_finish;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            soft_reset <= 1'h0;
            timebase_hold_clear <= 1'h0;
            readback_on <= 1'h0;
            led2_sample_begin <= `OAC_RESET_COUNT;
            led2_sample_finish <= `OAC_RESET_COUNT;
            led1_drive_begin <= `OAC_RESET_COUNT;
            powerdown_window_finish <= `OAC_RESET_COUNT;
            timing_pulse_begin <= `OAC_RESET_COUNT;
            timing_pulse_finish <= `OAC_RESET_COUNT;
            led3_drive_begin <= `OAC_RESET_COUNT;
            led3_drive_finish <= `OAC_RESET_COUNT;
            pulse_rate_divider_out <= 3'h0;
            offset_cancel_out <= 20'h00000;
            decimation_on_out <= 1'h0;
            decimation_ratio_out <= 3'h0;
        end
        else if (soft_reset)
        begin
            soft_reset <= 1'h0; // see (R1)
            timebase_hold_clear <= 1'h0; // see (R9)
            readback_on <= 1'h0;
            led2_sample_begin <= `OAC_RESET_COUNT;
            led2_sample_finish <= `OAC_RESET_COUNT;
            led1_drive_begin <= `OAC_RESET_COUNT;
            powerdown_window_finish <= `OAC_RESET_COUNT;
            timing_pulse_begin <= `OAC_RESET_COUNT;
            timing_pulse_finish <= `OAC_RESET_COUNT;
            led3_drive_begin <= `OAC_RESET_COUNT;
            led3_drive_finish <= `OAC_RESET_COUNT;
            pulse_rate_divider_out <= 3'h0;
            offset_cancel_out <= 20'h00000;
            decimation_on_out <= 1'h0;
            decimation_ratio_out <= 3'h0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                soft_reset <= wr_word[`OAC_BIT_SOFT_RESET]; // see (R1)
                timebase_hold_clear <= wr_word[`OAC_BIT_HOLD_CLEAR];
                readback_on <= wr_word[`OAC_BIT_READBACK]; // see (R3)
            end
            if (wr_led2_begin)
                led2_sample_begin <= wr_word[15:0]; // see (R6)
            if (wr_led2_finish)
                led2_sample_finish <= wr_word[15:0]; // see (R7)
            if (wr_led1_begin)
                led1_drive_begin <= wr_word[15:0]; // see (R8)
            if (wr_pdn_finish)
                powerdown_window_finish <= wr_word[15:0];
            if (wr_tg_begin)
                timing_pulse_begin <= wr_word[15:0];
            if (wr_tg_finish)
                timing_pulse_finish <= wr_word[15:0];
            if (wr_led3_begin)
                led3_drive_begin <= wr_word[15:0];
            if (wr_led3_finish)
                led3_drive_finish <= wr_word[15:0];
            if (wr_prf)
                pulse_rate_divider_out <= wr_word[`OAC_PRF_DIV_MSB:0];
            if (wr_offset)
                offset_cancel_out <= wr_word[`OAC_OFFSET_DAC_MSB:0];
            if (wr_dec)
            begin
                decimation_on_out <= wr_word[`OAC_BIT_DEC_ON];
                decimation_ratio_out <= wr_word[`OAC_DEC_RATIO_MSB:`OAC_DEC_RATIO_LSB];
            end
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    function automatic logic [23:0] pad16(input logic [15:0] v);
        pad16 = {8'h00, v};
    endfunction

    wire is_result = hit(reg_addr, `OAC_ADDR_AVG_LED2) | hit(reg_addr, `OAC_ADDR_AVG_LED1);
    logic [23:0] config_word;
    always_comb
    begin
        unique case (reg_addr)
            `OAC_ADDR_LED2_BEGIN: config_word = pad16(led2_sample_begin);
            `OAC_ADDR_LED2_FINISH: config_word = pad16(led2_sample_finish);
            `OAC_ADDR_LED1_BEGIN: config_word = pad16(led1_drive_begin);
            `OAC_ADDR_PDN_FINISH: config_word = pad16(powerdown_window_finish);
            `OAC_ADDR_TG_BEGIN: config_word = pad16(timing_pulse_begin);
            `OAC_ADDR_TG_FINISH: config_word = pad16(timing_pulse_finish);
            `OAC_ADDR_LED3_BEGIN: config_word = pad16(led3_drive_begin);
            `OAC_ADDR_LED3_FINISH: config_word = pad16(led3_drive_finish);
            `OAC_ADDR_PRF_DIV: config_word = {21'h000000, pulse_rate_divider_out};
            `OAC_ADDR_OFFSET_DAC: config_word = {4'h0, offset_cancel_out};
            `OAC_ADDR_DECIMATION: config_word = {18'h00000, decimation_on_out, 1'h0, decimation_ratio_out, 1'h0};
            default: config_word = `OAC_RESET_WORD; // see (R5)
        endcase
    end

    wire [23:0] result_word = hit(reg_addr, `OAC_ADDR_AVG_LED2) ? avg_led2_minus_ambient_in : avg_led1_minus_ambient_in;
    // results ignore the readback bit, configuration needs it
    assign read_word = is_result ? result_word : (readback_on ? config_word : `OAC_RESET_WORD); // see (R3) (R4)

    // ----------------------------------------
    // timebase and phases
    // ----------------------------------------
    function automatic logic in_window(input logic [15:0] cnt, input logic [15:0] first, input logic [15:0] last);
        in_window = (cnt >= first) && (cnt <= last);
    endfunction

    logic [15:0] timebase;
    wire [15:0] next_timebase = (timebase == TIMEBASE_LAST) ? `OAC_RESET_COUNT : timebase + 16'h0001;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            timebase <= `OAC_RESET_COUNT;
            led2_sample_phase_out <= 1'h0;
            led1_drive_begin_out <= 1'h0;
            timing_pulse_phase_out <= 1'h0;
            led3_drive_phase_out <= 1'h0;
            powerdown_window_finish_out <= 1'h0;
        end
        else
        begin
            timebase <= (timebase_hold_clear | soft_reset) ? `OAC_RESET_COUNT : next_timebase; // see (R2) (R9)
            led2_sample_phase_out <= in_window(timebase, led2_sample_begin, led2_sample_finish); // see (R10)
            led1_drive_begin_out <= (timebase == led1_drive_begin);
            timing_pulse_phase_out <= in_window(timebase, timing_pulse_begin, timing_pulse_finish); // see (R10)
            led3_drive_phase_out <= in_window(timebase, led3_drive_begin, led3_drive_finish);
            powerdown_window_finish_out <= (timebase == powerdown_window_finish);
        end
    end
    assign timebase_count_out = timebase;
endmodule

// ==== core/oac_consts.svh ====
// register offsets, field positions, reset values and link constants of the control bank
// assumes inclusion by bare name from the design files
`ifndef OAC_CONSTS_SVH
`define OAC_CONSTS_SVH

`define OAC_ADDR_CONTROL 8'h00
`define OAC_ADDR_LED2_BEGIN 8'h01
`define OAC_ADDR_LED2_FINISH 8'h02
`define OAC_ADDR_LED1_BEGIN 8'h03
`define OAC_ADDR_PDN_FINISH 8'h33
`define OAC_ADDR_TG_BEGIN 8'h34
`define OAC_ADDR_TG_FINISH 8'h35
`define OAC_ADDR_LED3_BEGIN 8'h36
`define OAC_ADDR_LED3_FINISH 8'h37
`define OAC_ADDR_PRF_DIV 8'h39
`define OAC_ADDR_OFFSET_DAC 8'h3A
`define OAC_ADDR_DECIMATION 8'h3D
`define OAC_ADDR_AVG_LED2 8'h3F
`define OAC_ADDR_AVG_LED1 8'h40

`define OAC_BIT_READBACK 0
`define OAC_BIT_HOLD_CLEAR 1
`define OAC_BIT_SOFT_RESET 3
`define OAC_BIT_DEC_ON 5
`define OAC_DEC_RATIO_MSB 3
`define OAC_DEC_RATIO_LSB 1
`define OAC_PRF_DIV_MSB 2
`define OAC_OFFSET_DAC_MSB 19

`define OAC_RESET_WORD 24'h000000
`define OAC_RESET_COUNT 16'h0000
// arbitrary 7-bit bus address of this device
`define OAC_BUS_ADDRESS 7'h2A
`define OAC_BYTES_PER_WORD 2'h3

`endif

// ==== core/oac_pkg.sv ====
// types shared by the control bank and its serial link slave
// assumes oac_consts.svh is compiled alongside
package oac_pkg;
    typedef enum logic [8:0] {
        OAC_ST_IDLE = 9'h001,
        OAC_ST_ADDR = 9'h002,
        OAC_ST_ACK_ADDR = 9'h004,
        OAC_ST_REG = 9'h008,
        OAC_ST_ACK_REG = 9'h010,
        OAC_ST_WDATA = 9'h020,
        OAC_ST_ACK_W = 9'h040,
        OAC_ST_RDATA = 9'h080,
        OAC_ST_RACK = 9'h100
    } oac_link_state_type;
endpackage

// ==== core/oac_link_slave.sv ====
// two-wire serial slave: device address, register address, 24-bit words msb first
// assumes scl and sda arrive asynchronously; sda is open drain, oe high pulls it low
`timescale 1ns/10ps
`include "oac_consts.svh"

module oac_link_slave
    import oac_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [23:0] rd_word_in,
    output logic [7:0] reg_addr_out,
    output logic [23:0] wr_word_out,
    output logic wr_pulse_out
);
    // ----------------------------------------
    // synchronisers
    // ----------------------------------------
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'h1;
            sda_prev <= 1'h1;
        end
        else
        begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end
    wire scl_s = scl_sync[1];
    wire sda_s = sda_sync[1];
    wire scl_rise = scl_s & ~scl_prev;
    wire scl_fall = ~scl_s & scl_prev;
    wire start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
    wire stop_seen = scl_s & scl_prev & ~sda_prev & sda_s;

    // ----------------------------------------
    // byte engine
    // ----------------------------------------
    oac_link_state_type state;
    logic [7:0] shift;
    logic [3:0] bit_cnt;
    logic [1:0] byte_idx;
    logic rd_mode;
    logic [23:0] tx_word;
    wire byte_done = (bit_cnt == 4'h8);
    wire last_byte = (byte_idx == `OAC_BYTES_PER_WORD - 2'h1);
    wire [7:0] tx_byte = (byte_idx == 2'h0) ? tx_word[23:16] : (byte_idx == 2'h1) ? tx_word[15:8] : tx_word[7:0];
    wire [7:0] first_byte = rd_word_in[23:16];
    wire [2:0] tx_pos = 3'h7 - bit_cnt[2:0];

    assign sda_out = 1'h0;

    always_ff @(posedge ref_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state <= OAC_ST_IDLE;
            shift <= 8'h00;
            bit_cnt <= 4'h0;
            byte_idx <= 2'h0;
            rd_mode <= 1'h0;
            tx_word <= 24'h000000;
            sda_oe_out <= 1'h0;
            reg_addr_out <= 8'h00;
            wr_word_out <= 24'h000000;
            wr_pulse_out <= 1'h0;
        end
        else
        begin
            wr_pulse_out <= 1'h0;
            if (stop_seen)
            begin
                state <= OAC_ST_IDLE;
                sda_oe_out <= 1'h0;
            end
            else if (start_seen)
            begin
                state <= OAC_ST_ADDR;
                bit_cnt <= 4'h0;
                sda_oe_out <= 1'h0;
            end
            else if (scl_rise)
            begin
                unique case (state)
                    OAC_ST_ADDR, OAC_ST_REG, OAC_ST_WDATA:
                    begin
                        shift <= {shift[6:0], sda_s};
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                    OAC_ST_RDATA:
                        bit_cnt <= bit_cnt + 4'h1;
                    OAC_ST_RACK:
                        if (sda_s)
                            state <= OAC_ST_IDLE;
                    default:
                    begin
                    end
                endcase
            end
            else if (scl_fall)
            begin
                unique case (state)
                    OAC_ST_ADDR:
                        if (byte_done)
                        begin
                            if (shift[7:1] == `OAC_BUS_ADDRESS)
                            begin
                                state <= OAC_ST_ACK_ADDR;
                                rd_mode <= shift[0];
                                sda_oe_out <= 1'h1;
                            end
                            else
                                state <= OAC_ST_IDLE;
                        end
                    OAC_ST_ACK_ADDR:
                    begin
                        bit_cnt <= 4'h0;
                        byte_idx <= 2'h0;
                        if (rd_mode)
                        begin
                            state <= OAC_ST_RDATA;
                            tx_word <= rd_word_in;
                            sda_oe_out <= ~first_byte[7];
                        end
                        else
                        begin
                            state <= OAC_ST_REG;
                            sda_oe_out <= 1'h0;
                        end
                    end
                    OAC_ST_REG, OAC_ST_WDATA:
                        if (byte_done)
                        begin
                            state <= (state == OAC_ST_REG) ? OAC_ST_ACK_REG : OAC_ST_ACK_W;
                            if (state == OAC_ST_REG)
                                reg_addr_out <= shift;
                            else
                                wr_word_out <= {wr_word_out[15:0], shift};
                            sda_oe_out <= 1'h1;
                        end
                    OAC_ST_ACK_REG:
                    begin
                        state <= OAC_ST_WDATA;
                        bit_cnt <= 4'h0;
                        byte_idx <= 2'h0;
                        sda_oe_out <= 1'h0;
                    end
                    OAC_ST_ACK_W:
                    begin
                        state <= OAC_ST_WDATA;
                        bit_cnt <= 4'h0;
                        sda_oe_out <= 1'h0;
                        byte_idx <= last_byte ? 2'h0 : byte_idx + 2'h1;
                        if (last_byte)
                            wr_pulse_out <= 1'h1;
                    end
                    OAC_ST_RDATA:
                        if (byte_done)
                        begin
                            state <= OAC_ST_RACK;
                            sda_oe_out <= 1'h0;
                        end
                        else
                            sda_oe_out <= ~tx_byte[tx_pos];
                    OAC_ST_RACK:
                    begin
                        state <= OAC_ST_RDATA;
                        bit_cnt <= 4'h0;
                        byte_idx <= last_byte ? 2'h0 : byte_idx + 2'h1;
                        if (last_byte)
                        begin
                            tx_word <= rd_word_in;
                            sda_oe_out <= ~first_byte[7];
                        end
                        else
                            sda_oe_out <= (byte_idx == 2'h0) ? ~tx_word[15] : ~tx_word[7];
                    end
                    default:
                    begin
                    end
                endcase
            end
        end
    end
endmodule

// ==== bench/oac_host_model.sv ====
// two-wire host model driving the bank's serial link
// assumes a pull-up on sda; the device pulls sda low while its enable is high
`timescale 1ns/10ps
`include "oac_consts.svh"

module oac_host_model
(
    input wire logic ref_clk_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_pull_out
);
    logic ack;

    initial
    begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    // one scl period, sampled at end of scl high
    task automatic send_bit(input logic b, output logic r);
        sda_pull_out <= ~b;
        tick(6);
        scl_out <= 1'b1;
        tick(6);
        r = sda_in;
        scl_out <= 1'b0;
        tick(1);
    endtask

    task automatic start_cond();
        sda_pull_out <= 1'b0;
        tick(6);
        scl_out <= 1'b1;
        tick(6);
        sda_pull_out <= 1'b1;
        tick(6);
        scl_out <= 1'b0;
        tick(1);
    endtask

    task automatic stop_cond();
        sda_pull_out <= 1'b1;
        tick(6);
        scl_out <= 1'b1;
        tick(6);
        sda_pull_out <= 1'b0;
        tick(6);
    endtask

    task automatic send_byte(input logic [7:0] d, output logic a);
        logic r;
        for (int i = 7; i >= 0; i--)
            send_bit(d[i], r);
        send_bit(1'b1, a);
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        for (int i = 7; i >= 0; i--)
            send_bit(1'b1, d[i]);
        send_bit(last, ack);
    endtask

    // msb byte first; nack flags a refused device address
    task automatic write_word(input logic [6:0] dev, input logic [7:0] addr, input logic [23:0] w,
                              output logic nack);
        start_cond();
        send_byte({dev, 1'b0}, nack);
        send_byte(addr, ack);
        for (int k = 2; k >= 0; k--)
            send_byte(w[k*8 +: 8], ack);
        stop_cond();
    endtask

    task automatic read_word(input logic [7:0] addr, output logic [23:0] w);
        start_cond();
        send_byte({`OAC_BUS_ADDRESS, 1'b0}, ack);
        send_byte(addr, ack);
        start_cond();
        send_byte({`OAC_BUS_ADDRESS, 1'b1}, ack);
        for (int k = 2; k >= 0; k--)
            get_byte(k == 0, w[k*8 +: 8]);
        stop_cond();
    endtask
endmodule

// ==== bench/oac_control_bank_sva.sv ====
// assertions on the ports of the control bank
// assumes one clock domain with an asynchronous active-low reset
`timescale 1ns/10ps

module oac_control_bank_sva
#(
    parameter logic [15:0] TIMEBASE_LAST = 16'hFFFF
)
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic [15:0] timebase_count_out,
    input wire logic led1_drive_begin_out,
    input wire logic powerdown_window_finish_out,
    input wire logic [2:0] pulse_rate_divider_out,
    input wire logic [19:0] offset_cancel_out,
    input wire logic decimation_on_out,
    input wire logic [2:0] decimation_ratio_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    AST_SDA_OPEN_DRAIN: assert property (sda_out == 1'b0)
        else $error("sda not low");
    AST_OE_MOVES_SCL_LOW: assert property ($changed(sda_oe_out) |-> !scl_in)
        else $error("oe moved, scl high");
    AST_OE_STANDS: assert property ($rose(sda_oe_out) |-> sda_oe_out [*6])
        else $error("oe too short");
    AST_COUNT_RANGE: assert property (timebase_count_out <= TIMEBASE_LAST)
        else $error("timebase beyond last value");
    AST_COUNT_STEP: assert property (timebase_count_out != $past(timebase_count_out) + 16'h0001
        |-> timebase_count_out == 16'h0000)
        else $error("bad timebase step");
    AST_RELEASE_CLEAR: assert property ($rose(rst_n_in) |-> timebase_count_out == 16'h0000
        && {offset_cancel_out, pulse_rate_divider_out, decimation_on_out, decimation_ratio_out} == 27'h0
        && !sda_oe_out)
        else $error("not clear at release");
    AST_LED1_ONE_SHOT: assert property (led1_drive_begin_out && $changed(timebase_count_out)
        && |timebase_count_out |=> !led1_drive_begin_out)
        else $error("led1 pulse too long");
    AST_PDN_ONE_SHOT: assert property (powerdown_window_finish_out && $changed(timebase_count_out)
        && |timebase_count_out |=> !powerdown_window_finish_out)
        else $error("pdn pulse too long");
endmodule

bind oac_control_bank oac_control_bank_sva #(.TIMEBASE_LAST(TIMEBASE_LAST)) u_oac_control_bank_sva (
    .ref_clk_in, .rst_n_in, .scl_in, .sda_out, .sda_oe_out, .timebase_count_out, .led1_drive_begin_out,
    .powerdown_window_finish_out, .pulse_rate_divider_out, .offset_cancel_out, .decimation_on_out,
    .decimation_ratio_out);

// ==== bench/oac_control_bank_tb_top.sv ====
// self-checking bench of the control bank
// assumes the short timebase parameter below and a pull-up on sda
`timescale 1ns/10ps
`include "oac_consts.svh"

module oac_control_bank_tb_top
    import oac_pkg::*;
;
    logic ref_clk_in, rst_n_in, scl, sda_pull, sda_oe, sda_val, sda_line, n;
    logic [23:0] avg2, avg1, got;
    logic [15:0] count, b, f, s, c_prev;
    logic led2_ph, led1_p, tg_ph, led3_ph, pdn_p, dec_on;
    logic [2:0] div, ratio;
    logic [19:0] offs;
    logic [23:0] mirror [0:64];
    int n_mismatch = 0;
    int cmp_count = 0;
    logic [7:0] cfg_addr [11] = '{8'h01, 8'h02, 8'h03, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37, 8'h39, 8'h3A, 8'h3D};
    logic [23:0] cfg_mask [11] = '{24'hFFFF, 24'hFFFF, 24'hFFFF, 24'hFFFF, 24'hFFFF, 24'hFFFF, 24'hFFFF,
                                   24'hFFFF, 24'h7, 24'hFFFFF, 24'h2E};

    assign sda_line = !(sda_pull || (sda_oe && !sda_val));
    oac_control_bank #(.TIMEBASE_LAST(16'h003F)) u_oac_control_bank (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_val), .sda_oe_out(sda_oe),
        .avg_led2_minus_ambient_in(avg2), .avg_led1_minus_ambient_in(avg1), .timebase_count_out(count),
        .led2_sample_phase_out(led2_ph), .led1_drive_begin_out(led1_p), .timing_pulse_phase_out(tg_ph),
        .led3_drive_phase_out(led3_ph), .powerdown_window_finish_out(pdn_p), .pulse_rate_divider_out(div),
        .offset_cancel_out(offs), .decimation_on_out(dec_on), .decimation_ratio_out(ratio));
    oac_host_model u_oac_host_model (.ref_clk_in(ref_clk_in), .sda_in(sda_line), .scl_out(scl),
        .sda_pull_out(sda_pull));
    function automatic logic in_win(input logic [15:0] c, input logic [23:0] lo, input logic [23:0] hi);
        return c >= lo[15:0] && c <= hi[15:0];
    endfunction

    task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t word %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        chk_word({23'h0, g}, {23'h0, e});
    endtask

    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        u_oac_host_model.write_word(`OAC_BUS_ADDRESS, a, d, n);
        mirror[a] = d;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [23:0] e);
        u_oac_host_model.read_word(a, got);
        chk_word(got, e);
    endtask

    task automatic stop_test();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        ref_clk_in = 1'b0;
        forever #10 ref_clk_in = ~ref_clk_in;
    end

    initial
    begin
        repeat (90000) @(posedge ref_clk_in);
        n_mismatch++;
        stop_test();
    end

    initial
    begin
        rst_n_in = 1'b0;
        avg2 = 24'h000000;
        avg1 = 24'h000000;
        mirror = '{default: 24'h000000};
        void'($urandom(32'h1E1B));
        repeat (5) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge ref_clk_in);
        wr(8'h01, 24'h00A5C3);
        rd_chk(8'h01, 24'h000000);
        wr(8'h00, 24'h000001);
        rd_chk(8'h01, 24'h00A5C3);
        rd_chk(8'h00, 24'h000000);
        for (int i = 1; i < 11; i++)
            rd_chk(cfg_addr[i], 24'h000000);
        for (int i = 0; i < 11; i++)
        begin
            wr(cfg_addr[i], $urandom() & cfg_mask[i]);
            rd_chk(cfg_addr[i], mirror[cfg_addr[i]]);
        end
        chk_word({offs, div, dec_on}, {mirror[58][19:0], mirror[57][2:0], mirror[61][5]});
        chk_word(24'(ratio), 24'(mirror[61][3:1]));
        wr(8'h00, 24'h000003);
        repeat (8)
        begin
            @(negedge ref_clk_in);
            chk_word(24'(count), 24'h000000);
        end
        b = 16'($urandom_range(1, 30));
        f = b + 16'($urandom_range(0, 30));
        s = 16'($urandom_range(1, 62));
        wr(8'h01, {8'h00, b});
        wr(8'h02, {8'h00, f});
        wr(8'h03, {8'h00, s});
        wr(8'h34, {8'h00, s});
        wr(8'h35, {8'h00, f});
        wr(8'h00, 24'h000001);
        @(negedge ref_clk_in);
        c_prev = count;
        repeat (70)
        begin
            @(negedge ref_clk_in);
            chk_bit(led2_ph, in_win(c_prev, mirror[1], mirror[2]));
            chk_bit(led1_p, c_prev == mirror[3][15:0]);
            chk_bit(tg_ph, in_win(c_prev, mirror[52], mirror[53]));
            chk_bit(led3_ph, in_win(c_prev, mirror[54], mirror[55]));
            chk_bit(pdn_p, c_prev == mirror[51][15:0]);
            c_prev = count;
        end
        u_oac_host_model.write_word(7'h15, 8'h01, 24'h001234, n);
        chk_bit(n, 1'b1);
        rd_chk(8'h01, mirror[1]);
        wr(8'h00, 24'h000008);
        mirror = '{default: 24'h000000};
        repeat (4) @(negedge ref_clk_in);
        chk_word({offs, div, dec_on}, 24'h000000);
        c_prev = count;
        @(negedge ref_clk_in);
        chk_bit(count != c_prev, 1'b1);
        @(posedge ref_clk_in);
        avg2 <= 24'($urandom());
        avg1 <= 24'($urandom());
        @(posedge ref_clk_in);
        rd_chk(8'h3F, avg2);
        wr(8'h00, 24'h000001);
        rd_chk(8'h40, avg1);
        rd_chk(8'h01, 24'h000000);
        rd_chk(8'h3A, 24'h000000);
        stop_test();
    end
endmodule
